// [design/uart_modem_pin_routing.v]
// glue between host pins, uart core and modem datapath
// assumes uart core and modem on clk_i; pins asynchronous
//
// What this block does
// (R1) uart access only while select low
// (R2) single-port mode latches select on strobe
// (R3) interrupt output follows uart interrupt condition
// (R4) legacy bit zero gates interrupt by read
// (R5) interrupt output three-state by enable bit
// (R6) single-port adds modem detect interrupt
// (R7) dual-port, route clear: receive pin outputs modem
// (R8) single-port, route clear: receive pin ignored
// (R9) route set: receive pin feeds uart
// (R10) transmit carries uart when dual or routed
// (R11) single-port, route clear: transmit held mark
// (R12) offhook driver is complement of control bit
// (R13) strap high selects single-port mode
// (R14) select latched when address strobe rises
// (R15) host reads by pulling read strobe low
// (R16) driven receive pin not fed to uart
`default_nettype none
`include "pin_routing_regs.vh"
module uart_modem_pin_routing (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // host pins
  input wire uart_select_n_i,
  input wire address_strobe_n_i,
  input wire read_strobe_n_i,
  input wire write_strobe_n_i,
  input wire single_port_strap_i,
  // interrupt pin
  output reg uart_irq_out_o,
  output reg uart_irq_out_oe_o,
  // serial pins
  input wire rxd_pin_i,
  output reg rxd_pin_o,
  output reg rxd_pin_oe_o,
  output reg txd_pin_o,
  // offhook open-drain pin
  output reg offhook_driver_o,
  output reg offhook_driver_oe_o,
  // core side control bits
  input wire uart_irq_pending_i,
  input wire modem_detect_irq_i,
  input wire legacy_irq_mode_bit_i,
  input wire irq_output_enable_bit_i,
  input wire uart_route_bit_i,
  input wire offhook_ctrl_bit_i,
  // serial data from cores
  input wire uart_txd_i,
  input wire modem_rx_valid_i,
  output wire modem_rx_ready_o,
  input wire modem_rx_bit_i,
  // core side access strobes
  output reg uart_read_en_o,
  output reg uart_write_en_o,
  output reg uart_rxd_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire sel_n_s;
  wire ads_n_s;
  wire rd_n_s;
  wire wr_n_s;
  wire strap_s;
  wire rxd_s;
  wire [5:0] pins_raw;
  wire [5:0] pins_s;
  // idle pin levels, so no false strobe edge after reset
  wire [5:0] pins_init;
  assign pins_init = `PIN_IDLE;
  assign pins_raw = {rxd_pin_i, single_port_strap_i, write_strobe_n_i,
                     read_strobe_n_i, address_strobe_n_i, uart_select_n_i};
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_sync
      pin_sync u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .init_i(pins_init[g]),
        .pin_i(pins_raw[g]),
        .level_o(pins_s[g])
      );
    end
  endgenerate
  assign sel_n_s = pins_s[0];
  assign ads_n_s = pins_s[1];
  assign rd_n_s = pins_s[2];
  assign wr_n_s = pins_s[3];
  assign strap_s = pins_s[4];
  assign rxd_s = pins_s[5];

  // ----------------------------------------
  // chip select capture
  // ----------------------------------------
  reg ads_n_q;
  reg sel_lat_n_q;
  wire ads_rise;
  wire sel_eff_n;
  assign ads_rise = ads_n_s & ~ads_n_q;
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ads_n_q <= `RST_HIGH;
      sel_lat_n_q <= `RST_HIGH;
    end
    else
    begin
      ads_n_q <= ads_n_s;
      if (ads_rise)
        sel_lat_n_q <= sel_n_s; // see (R14)
    end
  end
  // single-port uses latched select, dual-port the direct one
  assign sel_eff_n = strap_s ? sel_lat_n_q : sel_n_s; // see (R2) see (R13)

  // ----------------------------------------
  // access gating
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      uart_read_en_o <= `RST_LOW;
      uart_write_en_o <= `RST_LOW;
    end
    else
    begin
      uart_read_en_o <= ~sel_eff_n & ~rd_n_s; // see (R1) see (R15)
      uart_write_en_o <= ~sel_eff_n & ~wr_n_s; // see (R1)
    end
  end

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  reg irq_src;
  always @*
  begin
    irq_src = uart_irq_pending_i; // see (R3)
    if (strap_s)
      irq_src = irq_src | modem_detect_irq_i; // see (R6)
    if (!legacy_irq_mode_bit_i)
      irq_src = irq_src & ~rd_n_s; // see (R4)
  end
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      uart_irq_out_o <= `RST_LOW;
      uart_irq_out_oe_o <= `RST_LOW;
    end
    else
    begin
      uart_irq_out_o <= irq_src;
      uart_irq_out_oe_o <= irq_output_enable_bit_i; // see (R5)
    end
  end

  // ----------------------------------------
  // modem receive buffer
  // ----------------------------------------
  wire fifo_valid;
  wire fifo_bit;
  wire drive_rxd;
  reg rx_take;
  assign drive_rxd = ~strap_s & ~uart_route_bit_i;
  bit_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(modem_rx_valid_i),
    .in_ready_o(modem_rx_ready_o),
    .in_data_i(modem_rx_bit_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(rx_take),
    .out_data_o(fifo_bit)
  );
  // drain one bit per cycle only while the pin is an output
  always @*
  begin
    rx_take = drive_rxd & fifo_valid;
  end

  // ----------------------------------------
  // serial pin routing
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rxd_pin_o <= `MARK_LEVEL;
      rxd_pin_oe_o <= `RST_LOW;
      txd_pin_o <= `MARK_LEVEL;
      uart_rxd_o <= `MARK_LEVEL;
      offhook_driver_o <= `RST_LOW;
      offhook_driver_oe_o <= `RST_LOW;
    end
    else
    begin
      rxd_pin_oe_o <= drive_rxd; // see (R7)
      if (rx_take)
        rxd_pin_o <= fifo_bit; // see (R7)
      if (uart_route_bit_i)
        uart_rxd_o <= rxd_s; // see (R9)
      else
        uart_rxd_o <= `MARK_LEVEL; // see (R8) see (R16)
      if (~strap_s | uart_route_bit_i)
        txd_pin_o <= uart_txd_i; // see (R10)
      else
        txd_pin_o <= `MARK_LEVEL; // see (R11)
      // open drain: pin level is complement of bit, sink when low
      offhook_driver_o <= `RST_LOW;
      offhook_driver_oe_o <= offhook_ctrl_bit_i; // see (R12)
    end
  end
endmodule // uart_modem_pin_routing
`default_nettype wire

// [design/pin_routing_regs.vh]
// constants for the uart and modem pin routing glue
// assumes inclusion by bare name from design files
`ifndef PIN_ROUTING_REGS_VH
`define PIN_ROUTING_REGS_VH
`define FIFO_WIDTH 1
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define SYNC_STAGES 3
`define PIN_IDLE 6'h2f
`define MARK_LEVEL 1'h1
`define RST_LOW 1'h0
`define RST_HIGH 1'h1
`endif

// [design/pin_sync.v]
// three-stage synchroniser for one pin input
// assumes clk_i domain; change accepted when stages two and three agree
`default_nettype none
module pin_sync (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  input wire init_i,
  // pin
  input wire pin_i,
  output reg level_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s1_q <= init_i;
      s2_q <= init_i;
      s3_q <= init_i;
      level_o <= init_i;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level_o <= s3_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

// [design/bit_fifo.v]
// small synchronous fifo, flop storage
// assumes one clock, synchronous reset
`default_nettype none
`include "pin_routing_regs.vh"
module bit_fifo #(
  parameter WIDTH = `FIFO_WIDTH,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW
) (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  localparam [AW:0] FULL_CNT = DEPTH;
  assign in_ready_o = (cnt_q != FULL_CNT);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q] <= in_data_i;
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // bit_fifo
`default_nettype wire

// [verif/pin_routing_chk.sv]
// assertions on the routing glue ports
// assumes bind onto uart_modem_pin_routing
`default_nettype none
module pin_routing_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // watched ports
  input wire logic uart_select_n_i,
  input wire logic read_strobe_n_i,
  input wire logic single_port_strap_i,
  input wire logic uart_irq_pending_i,
  input wire logic legacy_irq_mode_bit_i,
  input wire logic uart_route_bit_i,
  input wire logic offhook_ctrl_bit_i,
  input wire logic uart_txd_i,
  input wire logic uart_irq_out_o,
  input wire logic rxd_pin_oe_o,
  input wire logic txd_pin_o,
  input wire logic offhook_driver_o,
  input wire logic offhook_driver_oe_o,
  input wire logic uart_read_en_o,
  input wire logic uart_write_en_o,
  input wire logic uart_rxd_o,
  input wire logic modem_rx_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // settle tracking
  // ----
  logic [3:0] up_q;
  logic [5:0] sh_q, rh_q, ch_q;
  logic rt_q, lg_q;
  always @(posedge clk_i)
  begin
    up_q <= sys_rst_i ? 4'h0 : up_q + {3'h0, up_q != 4'h8};
    sh_q <= {sh_q[4:0], single_port_strap_i};
    rh_q <= {rh_q[4:0], read_strobe_n_i};
    ch_q <= {ch_q[4:0], uart_select_n_i};
    rt_q <= uart_route_bit_i;
    lg_q <= legacy_irq_mode_bit_i;
  end
  wire logic ok = up_q == 4'h8;
  wire logic hi = ok & (&sh_q) & single_port_strap_i;
  wire logic lo = ok & ~(|sh_q) & ~single_port_strap_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_oh; ok |-> offhook_driver_oe_o == $past(offhook_ctrl_bit_i) && !offhook_driver_o; endproperty
  a_oh: assert property (p_oh) else $error("offhook wrong");
  property p_txm; hi && !rt_q |-> txd_pin_o; endproperty
  a_txm: assert property (p_txm) else $error("no mark");
  property p_txu; ok && (lo || rt_q) |-> txd_pin_o == $past(uart_txd_i); endproperty
  a_txu: assert property (p_txu) else $error("txd wrong");
  property p_rxo; (hi || lo) |-> rxd_pin_oe_o == (lo && !rt_q); endproperty
  a_rxo: assert property (p_rxo) else $error("rxd drive");
  property p_urx; ok && !rt_q |-> uart_rxd_o; endproperty
  a_urx: assert property (p_urx) else $error("rxd fed");
  property p_irq; lo && lg_q |-> uart_irq_out_o == $past(uart_irq_pending_i); endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_gate; ok && (&rh_q) && read_strobe_n_i && !lg_q |-> !uart_irq_out_o; endproperty
  a_gate: assert property (p_gate) else $error("irq ungated");
  property p_sel; lo && (&ch_q) && uart_select_n_i |-> !uart_read_en_o && !uart_write_en_o; endproperty
  a_sel: assert property (p_sel) else $error("access unselected");
  c_irq: cover property (uart_irq_out_o);
  c_rd: cover property (uart_read_en_o);
  c_full: cover property (!modem_rx_ready_o);
endmodule // pin_routing_chk
bind uart_modem_pin_routing pin_routing_chk chk (.*);
`default_nettype wire

// [verif/modem_src.sv]
// modem bit source feeding the receive fifo
// assumes word held until ready seen high
`default_nettype none
module modem_src (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // stream
  input wire logic run_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic bit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic t_q;
  always @(posedge clk_i)
  begin
    t_q <= sys_rst_i ? 1'h0 : ~t_q;
    valid_o <= ~sys_rst_i & (run_i | (valid_o & ~ready_i));
  end
  // toggling junk when idle
  assign bit_o = valid_o ? 1'h0 : t_q;
endmodule // modem_src
`default_nettype wire

// [verif/uart_modem_pin_routing_bench.sv]
// bench for the routing glue
// assumes design, checker and modem_src compiled
`default_nettype none
module uart_modem_pin_routing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, sys_rst_i = 1, ads_n = 1, wr_n = 1, run = 0, z;
  logic strap, route, leg, oeb, pend, det, utx, ctrl, sel_n, rd_n, rdrv;
  wire irq, irq_oe, rxo, rx_oe, txo, oh_oe, rden, wren, urx, mv, mr, mb;
  wire rx_pin = rx_oe ? rxo : rdrv;
  int n_fail = 0, samples_checked = 0;
  logic [10:0] r_in [6] = '{11'h1cb, 11'h526, 11'h1b0, 11'h6ce, 11'h6d5, 11'h0d6};
  logic [5:0] r_out [6] = '{6'h35, 6'h2c, 6'h1e, 6'h11, 6'h3c, 6'h1c};
  uart_modem_pin_routing dut (.clk_i, .sys_rst_i, .uart_select_n_i(sel_n), .address_strobe_n_i(ads_n),
    .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .single_port_strap_i(strap), .uart_irq_out_o(irq),
    .uart_irq_out_oe_o(irq_oe), .rxd_pin_i(rx_pin), .rxd_pin_o(rxo), .rxd_pin_oe_o(rx_oe), .txd_pin_o(txo),
    .offhook_driver_o(), .offhook_driver_oe_o(oh_oe), .uart_irq_pending_i(pend), .modem_detect_irq_i(det),
    .legacy_irq_mode_bit_i(leg), .irq_output_enable_bit_i(oeb), .uart_route_bit_i(route),
    .offhook_ctrl_bit_i(ctrl), .uart_txd_i(utx), .modem_rx_valid_i(mv), .modem_rx_ready_o(mr),
    .modem_rx_bit_i(mb), .uart_read_en_o(rden), .uart_write_en_o(wren), .uart_rxd_o(urx));
  modem_src src (.clk_i, .sys_rst_i, .run_i(run), .ready_i(mr), .valid_o(mv), .bit_o(mb));
  task chk(input logic [5:0] g, input logic [5:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task report_and_stop;
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  initial
    forever #12.5 clk_i = ~clk_i;
  initial
  begin
    #20us;
    n_fail++;
    report_and_stop;
  end
  initial
  begin
    {strap, route, leg, oeb, pend, det, utx, ctrl, sel_n, rd_n, rdrv} = r_in[5];
    wt(12);
    sys_rst_i = 0;
    foreach (r_in[i])
    begin
      {strap, route, leg, oeb, pend, det, utx, ctrl, sel_n, rd_n, rdrv} = r_in[i];
      wt(8);
      chk({irq, irq_oe, txo, urx, rden, oh_oe}, r_out[i]);
    end
    strap = 1;
    run = 1;
    wt(20);
    chk({4'h0, mr, rx_oe}, 6'h00);
    run = 0;
    strap = 0;
    z = 1;
    repeat (20) @(negedge clk_i) z &= rxo;
    chk({5'h0, z}, 6'h00);
    wt(30);
    chk({3'h0, mr, rx_oe, rxo}, 6'h06);
    {strap, sel_n, ads_n, rd_n, wr_n} = 5'h10;
    wt(8);
    ads_n = 1;
    wt(8);
    sel_n = 1;
    wt(8);
    chk({4'h0, rden, wren}, 6'h03);
    ads_n = 0;
    wt(8);
    ads_n = 1;
    wt(8);
    chk({4'h0, rden, wren}, 6'h00);
    {ctrl, pend, leg} = 3'h6;
    wt(8);
    sys_rst_i = 1;
    wt(2);
    chk({irq, rden, txo, urx, rxo, oh_oe}, 6'h0e);
    sys_rst_i = 0;
    wt(10);
    report_and_stop;
  end
endmodule // uart_modem_pin_routing_bench
`default_nettype wire
